//--- lum_pkg.sv
// package for the line unit register bank: offsets, fields, timing
// assumes a 10 MHz core clock and 32-bit axi4-lite access, one word per register
// Function
// - read-only identity byte at offset zero
// - upper identity nibble holds device type
// - lower identity nibble holds silicon revision
// - any write to reset register starts reset
// - software reset completes within one microsecond
// - sixteen-bit error tally, low then high byte
// - jitter registers exist for channel zero only
// - positive jitter peak twelve bits, split
// - negative jitter peak twelve bits, split
// - one shared 24-bit user pattern
// - three inband codes: send, activate, deactivate
// - edge select register for event sources
// - channel offsets relative, jitter block absolute
package lum_pkg;
  localparam int unsigned CLK_HZ      = 10000000;         // core clock rate
  localparam int unsigned SRST_NS     = 1000;             // longest soft reset time
  localparam int unsigned SRST_CYC    = (SRST_NS * (CLK_HZ / 1000000)) / 1000; // round down
  localparam logic [3:0]  SRST_CNT    = 4'(SRST_CYC);     // soft reset length in cycles
  // printed offsets are register indices; byte address is four times
  localparam logic [10:0] IX_ID       = 11'h000;
  localparam logic [10:0] IX_PD       = 11'h011;
  localparam logic [10:0] IX_PAT_L    = 11'h012;
  localparam logic [10:0] IX_PAT_M    = 11'h013;
  localparam logic [10:0] IX_PAT_H    = 11'h014;
  localparam logic [10:0] IX_IBL      = 11'h015;
  localparam logic [10:0] IX_IB_TX    = 11'h016;
  localparam logic [10:0] IX_IB_ACT   = 11'h017;
  localparam logic [10:0] IX_IB_DEACT = 11'h018;
  localparam logic [10:0] IX_LOOP     = 11'h019;
  localparam logic [10:0] IX_EDGE     = 11'h01a;
  localparam logic [10:0] IX_MASK0    = 11'h01b;
  localparam logic [10:0] IX_MASK1    = 11'h01c;
  localparam logic [10:0] IX_MASK2    = 11'h01d;
  localparam logic [10:0] IX_LINE_STATUS_0    = 11'h01e;
  localparam logic [10:0] IX_LINE_STATUS_1    = 11'h01f;
  localparam logic [10:0] IX_FLAG0    = 11'h020;
  localparam logic [10:0] IX_FLAG1    = 11'h021;
  localparam logic [10:0] IX_FLAG2    = 11'h022;
  localparam logic [10:0] IX_ERR_L    = 11'h023;
  localparam logic [10:0] IX_ERR_H    = 11'h024;
  localparam logic [10:0] IX_SRST     = 11'h040;
  localparam logic [10:0] IX_JM       = 11'h7e5;
  localparam logic [10:0] IX_JP_L     = 11'h7e6;
  localparam logic [10:0] IX_JP_H     = 11'h7e7;
  localparam logic [10:0] IX_JN_L     = 11'h7e8;
  localparam logic [10:0] IX_JN_H     = 11'h7e9;
  // writable and status field masks (reserved bits read zero)
  localparam logic [7:0]  PD_MASK     = 8'h0f;
  localparam logic [7:0]  IBL_MASK    = 8'h3f;
  localparam logic [7:0]  LOOP_MASK   = 8'h0f;
  localparam logic [7:0]  EDGE_MASK   = 8'h7f;
  localparam logic [7:0]  M0_MASK     = 8'hff;
  localparam logic [7:0]  M1_MASK     = 8'he3;
  localparam logic [7:0]  M2_MASK     = 8'h3f;
  localparam logic [7:0]  ST0_MASK    = 8'h9f;
  localparam logic [7:0]  JM_MASK     = 8'h07;
  localparam logic [7:0]  REG_RST     = 8'h00;        // reset value of rw registers other than the masks
  localparam logic [7:0]  MASK_RST    = 8'hff;        // events masked after reset
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

//--- lum_flag_if.sv
// interface carrying one bank of sticky event flags between modules
// assumes the top module drives events and clear strobes
`timescale 1ns/1ps
interface lum_flag_if;
  logic [7:0] event_v;   // event pulses from the line core
  logic [7:0] clr_v;     // write-one-to-clear strobes
  logic [7:0] flags;     // sticky flag state
  modport bank (input event_v, input clr_v, output flags);
  modport ctrl (output event_v, output clr_v, input flags);
endinterface

//--- lum_flag_bank.sv
// one bank of eight sticky event flags
// assumes synchronous event and clear strobes on the core clock
`timescale 1ns/1ps
module lum_flag_bank #(
  parameter logic [7:0] VALID = 8'hff        // implemented flag bits
) (
  input  wire logic CLK,                     // core clock
  input  wire logic rst_b,                   // async reset, active low
  input  wire logic srst,                    // soft reset, active high
  lum_flag_if.bank  fi                       // events, clears, flags
);
  logic [7:0] flags_q;                       // sticky state
  // set wins over clear in the same cycle
  always_ff @(posedge CLK or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= 8'h00;
    end else if (srst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= ((flags_q & ~fi.clr_v) | fi.event_v) & VALID;
    end
  end
  assign fi.flags = flags_q;
endmodule

//--- lum_regbank.sv
// per-channel register bank with axi4-lite slave, flags and soft reset
// assumes line core supplies status levels, event pulses, counter and jitter values
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module lum_regbank #(
  parameter logic [3:0] DEV_TYPE = 4'h5,     // arbitrary device type code
  parameter logic [3:0] DEV_REV  = 4'h1      // arbitrary revision code
) (
  input  wire logic        CLK,              // core clock
  input  wire logic        RST_B,            // async reset, active low
  input  wire logic [12:0] S_AXI_AWADDR,     // write address
  input  wire logic        S_AXI_AWVALID,    // write address valid
  output      logic        S_AXI_AWREADY,    // write address ready
  input  wire logic [31:0] S_AXI_WDATA,      // write data
  input  wire logic [3:0]  S_AXI_WSTRB,      // write strobes
  input  wire logic        S_AXI_WVALID,     // write data valid
  output      logic        S_AXI_WREADY,     // write data ready
  output      logic [1:0]  S_AXI_BRESP,      // write response
  output      logic        S_AXI_BVALID,     // write response valid
  input  wire logic        S_AXI_BREADY,     // write response ready
  input  wire logic [12:0] S_AXI_ARADDR,     // read address
  input  wire logic        S_AXI_ARVALID,    // read address valid
  output      logic        S_AXI_ARREADY,    // read address ready
  output      logic [31:0] S_AXI_RDATA,      // read data
  output      logic [1:0]  S_AXI_RRESP,      // read response
  output      logic        S_AXI_RVALID,     // read data valid
  input  wire logic        S_AXI_RREADY,     // read data ready
  input  wire logic [7:0]  LINE_STATUS_0_IN,         // live status bank 0
  input  wire logic [7:0]  LINE_STATUS_1_IN,         // live status bank 1
  input  wire logic [7:0]  EVT0_IN,          // event pulses bank 0
  input  wire logic [7:0]  EVT1_IN,          // event pulses bank 1
  input  wire logic [7:0]  EVT2_IN,          // event pulses bank 2
  input  wire logic [15:0] ERROR_TALLY,      // error counter value
  input  wire logic [11:0] POSITIVE_JITTER_PEAK, // positive peak result
  input  wire logic [11:0] NEGATIVE_JITTER_PEAK, // negative peak result
  output      logic [3:0]  PATTERN_DETECT,   // pattern detect control
  output      logic [23:0] USER_PATTERN_BITS, // shared gen/detect pattern
  output      logic [5:0]  INBAND_LOOP,      // inband loop lengths
  output      logic [7:0]  INBAND_TX_CODE_BITS, // transmit code
  output      logic [7:0]  INBAND_ACTIVATE_BITS, // activate target
  output      logic [7:0]  INBAND_DEACTIVATE_BITS, // deactivate target
  output      logic        AUTO_LOOP,        // automatic loopback enable
  output      logic        DIGITAL_LOOP,     // digital loopback
  output      logic        REMOTE_LOOP,      // remote loopback
  output      logic        ANALOG_LOOP,      // analog loopback
  output      logic [6:0]  EDGE_SELECT,      // event trigger edge select
  output      logic        JITTER_MEAS_HALT, // stop jitter measurement
  output      logic        JITTER_MEAS_METHOD, // measurement method
  output      logic        JITTER_MEAS_BANDWIDTH, // measurement bandwidth
  output      logic        SOFT_RESET,       // device soft reset, high
  output      logic        IRQ               // interrupt level, high
);
  // identity value fixed in hardware
  localparam logic [7:0] IDENTITY_BITS = {DEV_TYPE, DEV_REV};

  logic        aw_full_q;                    // write address held
  logic        w_full_q;                     // write data held
  logic [10:0] aw_ix_q;                      // held write index
  logic [7:0]  wdat_q;                       // held write byte
  logic        wlane_q;                      // byte lane 0 enabled
  logic        bvalid_q;                     // write response pending
  logic [1:0]  bresp_q;                      // write response code
  logic        rvalid_q;                     // read data pending
  logic [31:0] rdata_q;                      // read data register
  logic [1:0]  rresp_q;                      // read response code
  logic [3:0]  srst_cnt_q;                   // soft reset remaining cycles
  logic        srst;                         // soft reset active
  logic        wr_go;                        // write executes this cycle
  logic        wr_en;                        // byte write enabled
  logic        wr_hit;                       // write index mapped
  logic [7:0]  pd_q, pl_q, pm_q, ph_q;       // pattern control and bytes
  logic [7:0]  ibl_q, ibtx_q, iba_q, ibd_q;  // inband control and codes
  logic [7:0]  loop_q, edge_q, jm_q;         // loop, edge select, jitter cfg
  logic [7:0]  m0_q, m1_q, m2_q;             // interrupt masks
  logic [7:0]  rd_byte;                      // decoded read byte
  logic        rd_hit;                       // read index mapped
  logic [10:0] ar_ix;                        // read index

  lum_flag_if fl0 ();                        // flag bank 0 carrier
  lum_flag_if fl1 ();                        // flag bank 1 carrier
  lum_flag_if fl2 ();                        // flag bank 2 carrier

  // byte address to register index
  assign ar_ix = S_AXI_ARADDR[12:2];
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign wr_en = wr_go && wlane_q;

  // write address channel capture
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_full_q <= 1'b0;
      aw_ix_q   <= 11'h000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_q <= 1'b1;
      aw_ix_q   <= S_AXI_AWADDR[12:2];
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  // write data channel capture
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      w_full_q <= 1'b0;
      wdat_q   <= 8'h00;
      wlane_q  <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_q <= 1'b1;
      wdat_q   <= S_AXI_WDATA[7:0];
      wlane_q  <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = !aw_full_q;
  assign S_AXI_WREADY  = !w_full_q;

  // write address decode: two mapped runs plus two single slots
  always_comb begin
    wr_hit = (aw_ix_q == lum_pkg::IX_ID) || (aw_ix_q == lum_pkg::IX_SRST);
    if (aw_ix_q >= lum_pkg::IX_PD && aw_ix_q <= lum_pkg::IX_ERR_H) begin
      wr_hit = 1'b1;                         // per-channel run
    end
    if (aw_ix_q >= lum_pkg::IX_JM && aw_ix_q <= lum_pkg::IX_JN_H) begin
      wr_hit = 1'b1;                         // jitter run
    end
  end

  // write response
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_q <= 1'b0;
      bresp_q  <= lum_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? lum_pkg::RESP_OKAY : lum_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;

  // soft reset counter, any data value launches it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      srst_cnt_q <= 4'h0;
    end else if (wr_go && aw_ix_q == lum_pkg::IX_SRST) begin
      srst_cnt_q <= lum_pkg::SRST_CNT;
    end else if (srst_cnt_q != 4'h0) begin
      srst_cnt_q <= srst_cnt_q - 4'h1;       // ends within bound
    end
  end
  assign srst       = (srst_cnt_q != 4'h0);
  assign SOFT_RESET = srst;

  // pattern and inband code registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {pd_q, pl_q, pm_q, ph_q}      <= {4{lum_pkg::REG_RST}};
      {ibl_q, ibtx_q, iba_q, ibd_q} <= {4{lum_pkg::REG_RST}};
    end else if (srst) begin
      // soft reset clears like the pin, writes are ignored meanwhile
      {pd_q, pl_q, pm_q, ph_q}      <= {4{lum_pkg::REG_RST}};
      {ibl_q, ibtx_q, iba_q, ibd_q} <= {4{lum_pkg::REG_RST}};
    end else if (wr_en) begin
      // identity index falls through untouched
      unique case (aw_ix_q)
        lum_pkg::IX_PD:       pd_q   <= wdat_q & lum_pkg::PD_MASK;
        lum_pkg::IX_PAT_L:    pl_q   <= wdat_q;
        lum_pkg::IX_PAT_M:    pm_q   <= wdat_q;
        lum_pkg::IX_PAT_H:    ph_q   <= wdat_q;
        lum_pkg::IX_IBL:      ibl_q  <= wdat_q & lum_pkg::IBL_MASK;
        lum_pkg::IX_IB_TX:    ibtx_q <= wdat_q;
        lum_pkg::IX_IB_ACT:   iba_q  <= wdat_q;
        lum_pkg::IX_IB_DEACT: ibd_q  <= wdat_q;
        default: begin
        end
      endcase
    end
  end

  // loop, edge, mask and jitter config registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {loop_q, edge_q, jm_q} <= {3{lum_pkg::REG_RST}};
      m0_q   <= lum_pkg::MASK_RST & lum_pkg::M0_MASK;
      m1_q   <= lum_pkg::MASK_RST & lum_pkg::M1_MASK;
      m2_q   <= lum_pkg::MASK_RST & lum_pkg::M2_MASK;
    end else if (srst) begin
      {loop_q, edge_q, jm_q} <= {3{lum_pkg::REG_RST}};
      m0_q   <= lum_pkg::MASK_RST & lum_pkg::M0_MASK;
      m1_q   <= lum_pkg::MASK_RST & lum_pkg::M1_MASK;
      m2_q   <= lum_pkg::MASK_RST & lum_pkg::M2_MASK;
    end else if (wr_en) begin
      unique case (aw_ix_q)
        lum_pkg::IX_LOOP:  loop_q <= wdat_q & lum_pkg::LOOP_MASK;
        lum_pkg::IX_EDGE:  edge_q <= wdat_q & lum_pkg::EDGE_MASK;
        lum_pkg::IX_MASK0: m0_q   <= wdat_q & lum_pkg::M0_MASK;
        lum_pkg::IX_MASK1: m1_q   <= wdat_q & lum_pkg::M1_MASK;
        lum_pkg::IX_MASK2: m2_q   <= wdat_q & lum_pkg::M2_MASK;
        lum_pkg::IX_JM:    jm_q   <= wdat_q & lum_pkg::JM_MASK;
        default: begin
        end
      endcase
    end
  end

  // flag banks: events set, write-one clears
  assign fl0.event_v = EVT0_IN;
  assign fl1.event_v = EVT1_IN & lum_pkg::M1_MASK;
  assign fl2.event_v = EVT2_IN & lum_pkg::M2_MASK;
  assign fl0.clr_v = (wr_en && aw_ix_q == lum_pkg::IX_FLAG0) ? wdat_q : 8'h00;
  assign fl1.clr_v = (wr_en && aw_ix_q == lum_pkg::IX_FLAG1) ? wdat_q : 8'h00;
  assign fl2.clr_v = (wr_en && aw_ix_q == lum_pkg::IX_FLAG2) ? wdat_q : 8'h00;

  lum_flag_bank #(.VALID(lum_pkg::M0_MASK)) u_fb0 (
    .CLK   (CLK),
    .rst_b (RST_B),
    .srst  (srst),
    .fi    (fl0.bank)
  );
  lum_flag_bank #(.VALID(lum_pkg::M1_MASK)) u_fb1 (
    .CLK   (CLK),
    .rst_b (RST_B),
    .srst  (srst),
    .fi    (fl1.bank)
  );
  lum_flag_bank #(.VALID(lum_pkg::M2_MASK)) u_fb2 (
    .CLK   (CLK),
    .rst_b (RST_B),
    .srst  (srst),
    .fi    (fl2.bank)
  );

  // interrupt: mask bit one blocks the flag
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(fl0.flags & ~m0_q) | |(fl1.flags & ~m1_q) | |(fl2.flags & ~m2_q);
    end
  end

  // read decode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (ar_ix)
      lum_pkg::IX_ID:       rd_byte = IDENTITY_BITS;
      lum_pkg::IX_PD:       rd_byte = pd_q;
      lum_pkg::IX_PAT_L:    rd_byte = pl_q;
      lum_pkg::IX_PAT_M:    rd_byte = pm_q;
      lum_pkg::IX_PAT_H:    rd_byte = ph_q;
      lum_pkg::IX_IBL:      rd_byte = ibl_q;
      lum_pkg::IX_IB_TX:    rd_byte = ibtx_q;
      lum_pkg::IX_IB_ACT:   rd_byte = iba_q;
      lum_pkg::IX_IB_DEACT: rd_byte = ibd_q;
      lum_pkg::IX_LOOP:     rd_byte = loop_q;
      lum_pkg::IX_EDGE:     rd_byte = edge_q;
      lum_pkg::IX_MASK0:    rd_byte = m0_q;
      lum_pkg::IX_MASK1:    rd_byte = m1_q;
      lum_pkg::IX_MASK2:    rd_byte = m2_q;
      lum_pkg::IX_LINE_STATUS_0:    rd_byte = LINE_STATUS_0_IN & lum_pkg::ST0_MASK;
      lum_pkg::IX_LINE_STATUS_1:    rd_byte = LINE_STATUS_1_IN & lum_pkg::M1_MASK;
      lum_pkg::IX_FLAG0:    rd_byte = fl0.flags;
      lum_pkg::IX_FLAG1:    rd_byte = fl1.flags;
      lum_pkg::IX_FLAG2:    rd_byte = fl2.flags;
      lum_pkg::IX_ERR_L:    rd_byte = ERROR_TALLY[7:0];
      lum_pkg::IX_ERR_H:    rd_byte = ERROR_TALLY[15:8];
      lum_pkg::IX_SRST:     rd_byte = 8'h00; // no readable state
      lum_pkg::IX_JM:       rd_byte = jm_q;
      lum_pkg::IX_JP_L:     rd_byte = POSITIVE_JITTER_PEAK[7:0];
      lum_pkg::IX_JP_H:     rd_byte = {4'h0, POSITIVE_JITTER_PEAK[11:8]};
      lum_pkg::IX_JN_L:     rd_byte = NEGATIVE_JITTER_PEAK[7:0];
      lum_pkg::IX_JN_H:     rd_byte = {4'h0, NEGATIVE_JITTER_PEAK[11:8]};
      default:              rd_hit  = 1'b0; // unmapped
    endcase
  end

  // read channel, one read at a time
  assign S_AXI_ARREADY = !rvalid_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= lum_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= rd_hit ? lum_pkg::RESP_OKAY : lum_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA  = rdata_q;
  assign S_AXI_RRESP  = rresp_q;

  // control outputs from registers
  assign PATTERN_DETECT         = pd_q[3:0];
  assign USER_PATTERN_BITS      = {ph_q, pm_q, pl_q};   // one copy for gen and detect
  assign INBAND_LOOP            = ibl_q[5:0];
  assign INBAND_TX_CODE_BITS    = ibtx_q;
  assign INBAND_ACTIVATE_BITS   = iba_q;
  assign INBAND_DEACTIVATE_BITS = ibd_q;
  assign AUTO_LOOP              = loop_q[3];
  assign DIGITAL_LOOP           = loop_q[2];
  assign REMOTE_LOOP            = loop_q[1];
  assign ANALOG_LOOP            = loop_q[0];
  assign EDGE_SELECT            = edge_q[6:0];
  assign JITTER_MEAS_HALT       = jm_q[2];
  assign JITTER_MEAS_METHOD     = jm_q[1];
  assign JITTER_MEAS_BANDWIDTH  = jm_q[0];
endmodule

//--- lum_regbank_props.sv
// concurrent checks on the ports of the line unit register bank
// assumes lum_regbank with byte address = index * 4 and 8-bit data in the low byte
`timescale 1ns/1ps
module lum_regbank_props #(
  parameter logic [3:0] DEV_TYPE = 4'h5,       // identity type code handed on
  parameter logic [3:0] DEV_REV  = 4'h1        // identity revision handed on
) (
  input wire logic        CLK, // core clock
  input wire logic        RST_B, // async reset, active low
  input wire logic [12:0] S_AXI_AWADDR, // write address
  input wire logic        S_AXI_AWVALID, // write address valid
  input wire logic        S_AXI_AWREADY, // write address ready
  input wire logic        S_AXI_WVALID, // write data valid
  input wire logic        S_AXI_WREADY, // write data ready
  input wire logic        S_AXI_BVALID, // write response valid
  input wire logic [12:0] S_AXI_ARADDR, // read address
  input wire logic        S_AXI_ARVALID, // read address valid
  input wire logic        S_AXI_ARREADY, // read address ready
  input wire logic [31:0] S_AXI_RDATA, // read data
  input wire logic [1:0]  S_AXI_RRESP, // read response
  input wire logic        S_AXI_RVALID, // read data valid
  input wire logic [15:0] ERROR_TALLY, // error counter value
  input wire logic [11:0] POSITIVE_JITTER_PEAK, // positive peak
  input wire logic [11:0] NEGATIVE_JITTER_PEAK, // negative peak
  input wire logic [23:0] USER_PATTERN_BITS, // shared pattern
  input wire logic        SOFT_RESET, // soft reset level
  input wire logic        IRQ // interrupt level
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a read address taken at a given byte address
  sequence s_ar(logic [12:0] a);
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == a;
  endsequence
  // both halves of a write taken at the same edge
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  a_id_value: assert property (s_ar(13'h000) |=>
    S_AXI_RDATA == {24'h0, DEV_TYPE, DEV_REV}) else $error("identity read wrong");
  a_err_low: assert property (s_ar(13'h08c) |=>
    S_AXI_RDATA == {24'h0, $past(ERROR_TALLY[7:0])}) else $error("error low byte wrong");
  a_pos_high: assert property (s_ar(13'h1f9c) |=>
    S_AXI_RDATA == {28'h0, $past(POSITIVE_JITTER_PEAK[11:8])}) else $error("pos peak wrong");
  a_neg_high: assert property (s_ar(13'h1fa4) |=>
    S_AXI_RDATA == {28'h0, $past(NEGATIVE_JITTER_PEAK[11:8])}) else $error("neg peak wrong");
  a_unmapped_err: assert property (s_ar(13'h004) |=>
    S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
  a_srst_start: assert property (s_wr and S_AXI_AWADDR == 13'h100 |-> ##[1:3] SOFT_RESET)
    else $error("soft reset not launched");
  a_srst_bound: assert property ($rose(SOFT_RESET) |-> ##[1:10] !SOFT_RESET)
    else $error("soft reset too long");
  a_srst_clear: assert property (SOFT_RESET |=> USER_PATTERN_BITS == 24'h0)
    else $error("pattern kept in soft reset");
  // both halves are held one cycle before the response rises
  a_wr_answer: assert property (s_wr |=> ##1 S_AXI_BVALID)
    else $error("write response late");
  c_srst: cover property ($rose(SOFT_RESET));
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'b10);
endmodule
bind lum_regbank lum_regbank_props #(.DEV_TYPE(DEV_TYPE), .DEV_REV(DEV_REV)) i_props (.*);

//--- tb_lum_regbank.sv
// self-checking bench for the line unit register bank over axi4-lite
// assumes lum_pkg, lum_regbank and its bound checker are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_lum_regbank;
  localparam logic [3:0] TYP = 4'h9;                  // arbitrary type code
  localparam logic [3:0] REV = 4'h2;                  // arbitrary revision code
  localparam logic [1:0] OK = lum_pkg::RESP_OKAY;     // plain answer
  localparam logic [10:0] RW_IX [14] = '{lum_pkg::IX_PD, lum_pkg::IX_PAT_L, lum_pkg::IX_PAT_M,
    lum_pkg::IX_PAT_H, lum_pkg::IX_IBL, lum_pkg::IX_IB_TX, lum_pkg::IX_IB_ACT,
    lum_pkg::IX_IB_DEACT, lum_pkg::IX_LOOP, lum_pkg::IX_EDGE, lum_pkg::IX_MASK0,
    lum_pkg::IX_MASK1, lum_pkg::IX_MASK2, lum_pkg::IX_JM};
  localparam logic [7:0] RW_MK [14] = '{lum_pkg::PD_MASK, 8'hff, 8'hff, 8'hff, lum_pkg::IBL_MASK,
    8'hff, 8'hff, 8'hff, lum_pkg::LOOP_MASK, lum_pkg::EDGE_MASK, lum_pkg::M0_MASK,
    lum_pkg::M1_MASK, lum_pkg::M2_MASK, lum_pkg::JM_MASK};
  logic        CLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        S_AXI_RREADY, SOFT_RESET, IRQ;
  logic [12:0] S_AXI_AWADDR, S_AXI_ARADDR;             // byte addresses
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;               // bus data
  logic [3:0]  S_AXI_WSTRB;                            // byte strobes
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;               // responses
  logic [7:0]  LINE_STATUS_0_IN, LINE_STATUS_1_IN, EVT0_IN, EVT1_IN, EVT2_IN;
  logic [7:0]  INBAND_TX_CODE_BITS, INBAND_ACTIVATE_BITS, INBAND_DEACTIVATE_BITS;
  logic [15:0] ERROR_TALLY;                            // counter seen by software
  logic [11:0] POSITIVE_JITTER_PEAK, NEGATIVE_JITTER_PEAK;
  logic [23:0] USER_PATTERN_BITS;                      // shared pattern
  logic [6:0]  EDGE_SELECT;                            // edge choices
  int          err_total, checks_done, cyc, srst_cyc;  // tallies
  lum_regbank #(.DEV_TYPE(TYP), .DEV_REV(REV)) i_dut (.*, .PATTERN_DETECT(), .INBAND_LOOP(),
    .AUTO_LOOP(), .DIGITAL_LOOP(), .REMOTE_LOOP(), .ANALOG_LOOP(), .JITTER_MEAS_HALT(),
    .JITTER_MEAS_METHOD(), .JITTER_MEAS_BANDWIDTH());
  // 100 ns clock
  always #50 CLK = ~CLK;
  // cycles spent in soft reset, and the hang limit
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (SOFT_RESET === 1'b1) srst_cyc <= srst_cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end
  // one write, judged on its response
  task automatic wrc(input logic [10:0] ix, input logic [7:0] d, input logic [1:0] er = OK);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge CLK);
    b = 1'b0;
    S_AXI_AWADDR <= {ix, 2'b00};
    S_AXI_WDATA <= {24'h0, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    while (!b) begin
      @(negedge CLK);
      {aw, w, b, r} = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BRESP};
      @(posedge CLK);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    `CHK(r, er)
  endtask
  // one read, judged against the expected word and response
  task automatic rdc(input logic [10:0] ix, input logic [31:0] e, input logic [1:0] er = OK);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge CLK);
    v = 1'b0;
    S_AXI_ARADDR <= {ix, 2'b00};
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    while (!v) begin
      @(negedge CLK);
      {ar, v, d, r} = {S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RDATA, S_AXI_RRESP};
      @(posedge CLK);
      if (ar) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
    `CHK(d, e)
    `CHK(r, er)
  endtask
  task automatic t_identity();
    rdc(lum_pkg::IX_ID, {24'h0, TYP, REV});
    wrc(lum_pkg::IX_ID, 8'h0f);
    rdc(lum_pkg::IX_ID, {24'h0, TYP, REV});
    rdc(lum_pkg::IX_PD, 32'h0);
  endtask
  task automatic t_rw();
    logic [7:0] v, r;
    for (int i = 0; i < 14; i++) begin
      v = 8'h96 + 8'(i);
      r = (i > 9 && i < 13) ? lum_pkg::MASK_RST : lum_pkg::REG_RST;
      rdc(RW_IX[i], {24'h0, r & RW_MK[i]});
      wrc(RW_IX[i], v);
      rdc(RW_IX[i], {24'h0, v & RW_MK[i]});
    end
    `CHK(USER_PATTERN_BITS, 24'h999897)
    `CHK({INBAND_TX_CODE_BITS, INBAND_ACTIVATE_BITS, INBAND_DEACTIVATE_BITS}, 24'h9b9c9d)
    `CHK(EDGE_SELECT, 7'h1f)
  endtask
  task automatic t_values();
    {ERROR_TALLY, POSITIVE_JITTER_PEAK, NEGATIVE_JITTER_PEAK} <= {16'hbe3c, 12'h9a5, 12'h3c7};
    {LINE_STATUS_0_IN, LINE_STATUS_1_IN} <= 16'hffff;
    rdc(lum_pkg::IX_ERR_L, 32'h3c);
    rdc(lum_pkg::IX_ERR_H, 32'hbe);
    wrc(lum_pkg::IX_ERR_L, 8'h00);
    rdc(lum_pkg::IX_ERR_L, 32'h3c);
    rdc(lum_pkg::IX_JP_L, 32'ha5);
    rdc(lum_pkg::IX_JP_H, 32'h09);
    rdc(lum_pkg::IX_JN_L, 32'hc7);
    rdc(lum_pkg::IX_JN_H, 32'h03);
    rdc(lum_pkg::IX_LINE_STATUS_0, {24'h0, lum_pkg::ST0_MASK});
    rdc(lum_pkg::IX_LINE_STATUS_1, {24'h0, lum_pkg::M1_MASK});
  endtask
  task automatic t_unmapped();
    rdc(11'h001, 32'h0, lum_pkg::RESP_SLVERR);
    rdc(11'h7ea, 32'h0, lum_pkg::RESP_SLVERR);
    wrc(11'h025, 8'h11, lum_pkg::RESP_SLVERR);
  endtask
  // raise, mask and clear events; bank 0 bit 0 is its only unmasked bit, banks 1 and 2 keep the masks written in t_rw
  task automatic t_irq();
    wrc(lum_pkg::IX_MASK0, 8'hfe);
    {EVT0_IN, EVT1_IN, EVT2_IN} <= 24'h03ffff;
    @(posedge CLK);
    {EVT0_IN, EVT1_IN, EVT2_IN} <= 24'h0;
    repeat (3) @(negedge CLK);
    `CHK(IRQ, 1'b1)
    rdc(lum_pkg::IX_FLAG0, 32'h03);
    rdc(lum_pkg::IX_FLAG1, {24'h0, lum_pkg::M1_MASK});
    rdc(lum_pkg::IX_FLAG2, {24'h0, lum_pkg::M2_MASK});
    wrc(lum_pkg::IX_FLAG0, 8'h01);
    wrc(lum_pkg::IX_FLAG1, 8'hff);
    wrc(lum_pkg::IX_FLAG2, 8'hff);
    repeat (3) @(negedge CLK);
    `CHK(IRQ, 1'b0)
    rdc(lum_pkg::IX_FLAG0, 32'h02);
  endtask
  // soft reset by a zero write: bounded length, bank back to reset values
  task automatic t_soft();
    srst_cyc = 0;
    wrc(lum_pkg::IX_SRST, 8'h00);
    repeat (12) @(posedge CLK);
    `CHK(srst_cyc > 0 && srst_cyc <= int'(lum_pkg::SRST_CYC), 1'b1)
    rdc(lum_pkg::IX_PAT_L, 32'h0);
    rdc(lum_pkg::IX_MASK0, {24'h0, lum_pkg::MASK_RST});
    rdc(lum_pkg::IX_FLAG0, 32'h0);
    rdc(lum_pkg::IX_ID, {24'h0, TYP, REV});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {CLK, RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = {26'h0, 32'h0, 4'h1};
    {LINE_STATUS_0_IN, LINE_STATUS_1_IN, EVT0_IN, EVT1_IN, EVT2_IN, ERROR_TALLY} = '0;
    {POSITIVE_JITTER_PEAK, NEGATIVE_JITTER_PEAK, err_total, checks_done, cyc, srst_cyc} = '0;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    t_identity();
    t_rw();
    t_values();
    t_unmapped();
    t_irq();
    t_soft();
    test_done();
  end
endmodule
